// >>> verilog/subtract_skip_speed_swap_exec.sv
// execution of skip-if-clear, speed, subtract and nibble swap instructions
//
// What this block does
// - skip next instruction when tested bit clear
// - bit test: one cycle, two when skipping
// - carry flag lives in status bit 0
// - speed loads literal, leaves flags untouched
// - speed fields: power 7:6, source 5:4, divisor 3:0
// - speed takes one cycle at old divisor
// - new divisor applies from next instruction
// - memory minus W written back to memory
// - memory minus W written into W
// - literal minus W written into W
// - carry cleared on borrow, else set
// - nibble flag cleared on bit 3 borrow
// - zero flag set when result is zero
// - memory minus W minus not-carry, into memory
// - with borrow: result into W, memory intact
// - swap memory nibbles in place, flags untouched unless the swapped location is the status register
// - zero flag lives in status bit 2
`timescale 1ns/1ps
`default_nettype none

module subtract_skip_speed_swap_exec #(
    parameter logic [7:0] SPEED_INIT  = subskip_pkg::SPEED_RESET,
    parameter logic [8:0] STATUS_LOC  = subskip_pkg::STATUS_ADDR
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    output logic             instr_ready,
    output logic       [8:0] mem_raddr,
    input  wire logic  [7:0] mem_rdata,
    output logic             mem_we,
    output logic       [8:0] mem_waddr,
    output logic       [7:0] mem_wdata,
    output logic             retire,
    output logic             skip_next,
    output logic             unknown_op,
    output logic       [7:0] w_value,
    output logic       [7:0] status_flags,
    output logic       [7:0] cpu_speed_control,
    output logic       [1:0] power_down_select,
    output logic       [1:0] system_source_select,
    output logic       [3:0] core_divisor_select
);

    typedef struct packed {
        subskip_pkg::state_e          state;
        logic [subskip_pkg::COUNT_W-1:0] wait_count;
        logic [7:0]                   w;
        logic                         carry;
        logic                         nibble_borrow_flag;
        logic                         zero;
        logic [7:0]                   speed;
        logic                         we;
        logic [8:0]                   waddr;
        logic [7:0]                   wdata;
        logic                         retire;
        logic                         skip;
        logic                         unknown;
    } exec_s;

    exec_s cur;
    exec_s next_cur;

    // opcode match; the nine address bits and three bit-number bits sit below
    function automatic subskip_pkg::op_e decode(input logic [15:0] word);
        subskip_pkg::op_e op;
        op = subskip_pkg::OP_NONE;
        if (word[15:12] == subskip_pkg::OPC_SKIP_CLEAR) begin
            op = subskip_pkg::OP_SKIP_CLEAR;
        end else if (word[15:8] == subskip_pkg::OPC_SPEED) begin
            op = subskip_pkg::OP_SPEED;
        end else if (word[15:8] == subskip_pkg::OPC_SUB_LITERAL) begin
            op = subskip_pkg::OP_SUB_LIT;
        end else begin
            case (word[15:9])
                subskip_pkg::OPC_SUB_TO_MEM: begin
                    op = subskip_pkg::OP_SUB_MEM;
                end
                subskip_pkg::OPC_SUB_TO_W: begin
                    op = subskip_pkg::OP_SUB_W;
                end
                subskip_pkg::OPC_SUBC_TO_MEM: begin
                    op = subskip_pkg::OP_SUBC_MEM;
                end
                subskip_pkg::OPC_SUBC_TO_W: begin
                    op = subskip_pkg::OP_SUBC_W;
                end
                subskip_pkg::OPC_SWAP_MEM: begin
                    op = subskip_pkg::OP_SWAP_MEM;
                end
                default: begin
                    op = subskip_pkg::OP_NONE;
                end
            endcase
        end
        return op;
    endfunction

    // core clocks per instruction cycle: divisor code n divides by n plus one
    function automatic logic [subskip_pkg::COUNT_W-1:0] clocks_for(
        input logic [7:0] speed_reg,
        input logic       two_cycles
    );
        logic [subskip_pkg::COUNT_W-1:0] per_cycle;
        per_cycle = {2'b00, speed_reg[subskip_pkg::DIVISOR_LSB +: subskip_pkg::DIVISOR_W]}
                    + 6'h01;
        if (two_cycles) begin
            return per_cycle << 1;
        end
        return per_cycle;
    endfunction

    // status byte as seen by software; only the three flags are held here
    function automatic logic [7:0] status_byte(input exec_s s);
        logic [7:0] b;
        b = 8'h00;
        b[subskip_pkg::STATUS_CARRY_BIT]  = s.carry;
        b[subskip_pkg::STATUS_NIBBLE_BIT] = s.nibble_borrow_flag;
        b[subskip_pkg::STATUS_ZERO_BIT]   = s.zero;
        return b;
    endfunction

    // the five subtract forms; only these and a store into the status location rewrite the flags
    function automatic logic is_subtract(input subskip_pkg::op_e code);
        logic hit;
        hit = 1'b0;
        case (code)
            subskip_pkg::OP_SUB_MEM,
            subskip_pkg::OP_SUBC_MEM,
            subskip_pkg::OP_SUB_W,
            subskip_pkg::OP_SUBC_W,
            subskip_pkg::OP_SUB_LIT: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // forms that store a byte back into data memory
    function automatic logic is_store(input subskip_pkg::op_e code);
        logic hit;
        hit = 1'b0;
        case (code)
            subskip_pkg::OP_SUB_MEM,
            subskip_pkg::OP_SUBC_MEM,
            subskip_pkg::OP_SWAP_MEM: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // forms that take the inverted carry as borrow in
    function automatic logic uses_borrow(input subskip_pkg::op_e code);
        logic hit;
        hit = 1'b0;
        case (code)
            subskip_pkg::OP_SUBC_MEM,
            subskip_pkg::OP_SUBC_W: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // nibble exchange of one byte
    function automatic logic [7:0] swap_nibbles(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction

    subskip_pkg::op_e op;
    logic [8:0]       file_addr;
    logic [2:0]       bit_sel;
    logic [7:0]       literal_byte;
    logic [7:0]       operand;
    logic             accept;
    logic             tested_bit;
    logic             with_borrow;
    logic             sub_form;
    logic             store_form;
    logic [7:0]       alu_minuend;
    logic [7:0]       alu_diff;
    logic             alu_carry;
    logic             alu_nibble;
    logic             alu_zero;
    logic [subskip_pkg::COUNT_W-1:0] total_clocks;

    always_comb begin
        op           = decode(instr_word);
        file_addr    = instr_word[subskip_pkg::ADDR_LSB +: subskip_pkg::ADDR_W];
        bit_sel      = instr_word[subskip_pkg::BITSEL_LSB +: subskip_pkg::BITSEL_W];
        literal_byte = instr_word[subskip_pkg::LITERAL_LSB +: subskip_pkg::LITERAL_W];
        accept       = instr_valid && (cur.state == subskip_pkg::ST_IDLE);
        sub_form     = is_subtract(op);
        store_form   = is_store(op);
    end

    // the write of the previous instruction lands one clock late, so a read of the
    // same location in the following clock is forwarded rather than read stale
    always_comb begin
        if (file_addr == STATUS_LOC) begin
            operand = status_byte(cur);
        end else if (cur.we && (cur.waddr == file_addr)) begin
            operand = cur.wdata;
        end else begin
            operand = mem_rdata;
        end
        tested_bit  = operand[bit_sel];
        with_borrow = uses_borrow(op);
        if (op == subskip_pkg::OP_SUB_LIT) begin
            alu_minuend = literal_byte;
        end else begin
            alu_minuend = operand;
        end
    end

    // borrow in is the complement of the carry flag for the two with-borrow forms, zero for the others
    sub_borrow_alu u_alu (
        .minuend    (alu_minuend),
        .subtrahend (cur.w),
        .borrow_in  (with_borrow & ~cur.carry),
        .difference (alu_diff),
        .carry_out  (alu_carry),
        .nibble_out (alu_nibble),
        .zero_out   (alu_zero)
    );

    always_comb begin
        next_cur        = cur;
        next_cur.we     = 1'b0;
        next_cur.retire = 1'b0;
        total_clocks    = clocks_for(cur.speed, 1'b0);
        case (cur.state)
            subskip_pkg::ST_IDLE: begin
                if (accept) begin
                    next_cur.retire  = 1'b1;
                    next_cur.skip    = 1'b0;
                    next_cur.unknown = 1'b0;
                    next_cur.waddr   = file_addr;
                    case (op)
                        subskip_pkg::OP_SKIP_CLEAR: begin
                            next_cur.skip = ~tested_bit;
                            total_clocks  = clocks_for(cur.speed, ~tested_bit);
                        end
                        subskip_pkg::OP_SPEED: begin
                            // old divisor times this one; flags are not touched
                            next_cur.speed = literal_byte;
                        end
                        subskip_pkg::OP_SUB_MEM,
                        subskip_pkg::OP_SUBC_MEM: begin
                            next_cur.we    = 1'b1;
                            next_cur.wdata = alu_diff;
                        end
                        subskip_pkg::OP_SUB_W,
                        subskip_pkg::OP_SUBC_W,
                        subskip_pkg::OP_SUB_LIT: begin
                            next_cur.w = alu_diff;
                        end
                        subskip_pkg::OP_SWAP_MEM: begin
                            next_cur.we    = 1'b1;
                            next_cur.wdata = swap_nibbles(operand);
                        end
                        // unknown words still hold the port for one instruction cycle
                        default: begin
                            next_cur.unknown = 1'b1;
                        end
                    endcase
                    // a byte written to the status location lands on the flags
                    if (store_form && (file_addr == STATUS_LOC)) begin
                        next_cur.carry              = next_cur.wdata[subskip_pkg::STATUS_CARRY_BIT];
                        next_cur.nibble_borrow_flag = next_cur.wdata[subskip_pkg::STATUS_NIBBLE_BIT];
                        next_cur.zero               = next_cur.wdata[subskip_pkg::STATUS_ZERO_BIT];
                    end
                    // subtract flags win over a store into the status location
                    if (sub_form) begin
                        next_cur.carry              = alu_carry;
                        next_cur.nibble_borrow_flag = alu_nibble;
                        next_cur.zero               = alu_zero;
                    end
                    if (total_clocks > 6'h01) begin
                        next_cur.state      = subskip_pkg::ST_WAIT;
                        next_cur.wait_count = total_clocks - 6'h02;
                    end
                end
            end
            subskip_pkg::ST_WAIT: begin
                // holds off the next instruction for the rest of its clocks
                if (cur.wait_count == 6'h00) begin
                    next_cur.state = subskip_pkg::ST_IDLE;
                end else begin
                    next_cur.wait_count = cur.wait_count - 6'h01;
                end
            end
            default: begin
                next_cur.state = subskip_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cur.state              <= subskip_pkg::ST_IDLE;
            cur.wait_count         <= '0;
            cur.w                  <= subskip_pkg::W_RESET;
            cur.carry              <= 1'b0;
            cur.nibble_borrow_flag <= 1'b0;
            cur.zero               <= 1'b0;
            cur.speed              <= SPEED_INIT;
            cur.we                 <= 1'b0;
            cur.waddr              <= 9'h000;
            cur.wdata              <= 8'h00;
            cur.retire             <= 1'b0;
            cur.skip               <= 1'b0;
            cur.unknown            <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    always_comb begin
        instr_ready          = (cur.state == subskip_pkg::ST_IDLE);
        mem_raddr            = file_addr;
        mem_we               = cur.we;
        mem_waddr            = cur.waddr;
        mem_wdata            = cur.wdata;
        retire               = cur.retire;
        skip_next            = cur.skip;
        unknown_op           = cur.unknown;
        w_value              = cur.w;
        status_flags         = status_byte(cur);
        cpu_speed_control    = cur.speed;
        power_down_select    = cur.speed[subskip_pkg::POWER_DOWN_LSB +: subskip_pkg::POWER_DOWN_W];
        system_source_select = cur.speed[subskip_pkg::SOURCE_LSB +: subskip_pkg::SOURCE_W];
        core_divisor_select  = cur.speed[subskip_pkg::DIVISOR_LSB +: subskip_pkg::DIVISOR_W];
    end

endmodule

`default_nettype wire

// >>> verilog/subskip_pkg.sv
// shared constants for the subtract, skip, speed and swap execution block
`default_nettype none
package subskip_pkg;

    // opcode fields, matched against the top bits of the 16-bit word
    localparam logic [3:0] OPC_SKIP_CLEAR   = 4'h6;
    localparam logic [7:0] OPC_SPEED        = 8'h01;
    localparam logic [6:0] OPC_SUB_TO_MEM   = 7'h05;
    localparam logic [6:0] OPC_SUB_TO_W     = 7'h04;
    localparam logic [7:0] OPC_SUB_LITERAL  = 8'h7A;
    localparam logic [6:0] OPC_SUBC_TO_MEM  = 7'h25;
    localparam logic [6:0] OPC_SUBC_TO_W    = 7'h24;
    localparam logic [6:0] OPC_SWAP_MEM     = 7'h1D;

    // instruction word field positions
    localparam int ADDR_LSB      = 0;
    localparam int ADDR_W        = 9;
    localparam int BITSEL_LSB    = 9;
    localparam int BITSEL_W      = 3;
    localparam int LITERAL_LSB   = 0;
    localparam int LITERAL_W     = 8;

    // status register bit positions
    localparam int STATUS_CARRY_BIT  = 0;
    localparam int STATUS_NIBBLE_BIT = 1;
    localparam int STATUS_ZERO_BIT   = 2;

    // speed control register fields
    localparam int POWER_DOWN_LSB    = 6;
    localparam int POWER_DOWN_W      = 2;
    localparam int SOURCE_LSB        = 4;
    localparam int SOURCE_W          = 2;
    localparam int DIVISOR_LSB       = 0;
    localparam int DIVISOR_W         = 4;

    // reset values and default location of the status register in data memory
    localparam logic [7:0] SPEED_RESET   = 8'h00;
    localparam logic [7:0] W_RESET       = 8'h00;
    localparam logic [8:0] STATUS_ADDR   = 9'h003;

    // instruction cycles per instruction, and width of the clock counter
    localparam int CYCLES_PLAIN  = 1;
    localparam int CYCLES_SKIP   = 2;
    localparam int COUNT_W       = 6;

    typedef enum logic [3:0] {
        OP_NONE       = 4'h0,
        OP_SKIP_CLEAR = 4'h1,
        OP_SPEED      = 4'h2,
        OP_SUB_MEM    = 4'h3,
        OP_SUB_W      = 4'h4,
        OP_SUB_LIT    = 4'h5,
        OP_SUBC_MEM   = 4'h6,
        OP_SUBC_W     = 4'h7,
        OP_SWAP_MEM   = 4'h8
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } state_e;

endpackage

`default_nettype wire

// >>> verilog/sub_borrow_alu.sv
// 8-bit subtractor with borrow in and carry, nibble and zero results
`timescale 1ns/1ps
`default_nettype none

module sub_borrow_alu (
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    input  wire logic       borrow_in,
    output logic      [7:0] difference,
    output logic            carry_out,
    output logic            nibble_out,
    output logic            zero_out
);

    logic [8:0] full_diff;
    logic [4:0] low_diff;

    // one extra bit catches the borrow out of bit 7 and out of bit 3
    always_comb begin
        full_diff  = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
        low_diff   = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
        difference = full_diff[7:0];
        carry_out  = ~full_diff[8];
        nibble_out = ~low_diff[4];
        zero_out   = (full_diff[7:0] == 8'h00);
    end

endmodule

`default_nettype wire

// >>> dv/subskip_props.sv
// concurrent checks on the ports of the execution block
`timescale 1ns/1ps
`default_nettype none
module subskip_props (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic        instr_ready,
    input wire logic  [8:0] mem_raddr,
    input wire logic  [7:0] mem_rdata,
    input wire logic        mem_we,
    input wire logic  [8:0] mem_waddr,
    input wire logic  [7:0] mem_wdata,
    input wire logic        retire,
    input wire logic        skip_next,
    input wire logic        unknown_op,
    input wire logic  [7:0] w_value,
    input wire logic  [7:0] status_flags,
    input wire logic  [7:0] cpu_speed_control,
    input wire logic  [1:0] power_down_select,
    input wire logic  [1:0] system_source_select,
    input wire logic  [3:0] core_divisor_select
);
    logic       acc;
    logic       plain;
    logic [5:0] low_cnt;
    logic [3:0] div_q;
    logic       skip_q;
    logic       unk_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    assign acc = instr_valid && instr_ready;
    // memory data is only trusted when no own write is pending and status is not read
    assign plain = acc && instr_word[8:0] != subskip_pkg::STATUS_ADDR &&
                   !(mem_we && mem_waddr == mem_raddr);
    always_ff @(posedge core_clk) begin
        if (reset || acc)
            low_cnt <= 6'h00;
        else if (!instr_ready)
            low_cnt <= low_cnt + 6'h01;
        if (acc)
            div_q <= core_divisor_select;
        if (retire) begin
            skip_q <= skip_next;
            unk_q <= unknown_op;
        end
    end
    AST_RETIRE: assert property (acc |=> retire)
        else $error("no retire after accept");
    AST_INSTR_TIME: assert property ($rose(instr_ready) && !unk_q |->
        low_cnt == (skip_q ? 6'(2 * div_q + 1) : 6'(div_q)))
        else $error("instruction time wrong");
    AST_SPEED: assert property (acc && instr_word[15:8] == 8'h01 |=>
        cpu_speed_control == $past(instr_word[7:0]) && $stable(status_flags))
        else $error("speed load wrong");
    AST_FIELDS: assert property (cpu_speed_control ==
        {power_down_select, system_source_select, core_divisor_select})
        else $error("speed fields wrong");
    AST_SWAP: assert property (plain && instr_word[15:9] == 7'h1D |=> mem_we &&
        mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && $stable(status_flags))
        else $error("swap wrong");
    AST_SUB_MEM: assert property (acc && instr_word[14:9] inside {6'h05, 6'h25} &&
        !instr_word[15] |=> mem_we && mem_waddr == $past(instr_word[8:0]) && $stable(w_value))
        else $error("subtract to memory wrong");
    AST_LIT: assert property (acc && instr_word[15:8] == 8'h7A |=>
        w_value == $past(instr_word[7:0]) - $past(w_value) && !mem_we &&
        status_flags[2] == (w_value == 8'h00) &&
        status_flags[0] == ($past(instr_word[7:0]) >= $past(w_value)))
        else $error("literal subtract wrong");
    AST_SKIP: assert property (plain && instr_word[15:12] == 4'h6 |=>
        skip_next == !$past(mem_rdata[instr_word[11:9]]) && $stable(status_flags))
        else $error("skip decision wrong");
endmodule
bind subtract_skip_speed_swap_exec subskip_props u_props (
    .core_clk(core_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .retire(retire), .skip_next(skip_next),
    .unknown_op(unknown_op), .w_value(w_value), .status_flags(status_flags),
    .cpu_speed_control(cpu_speed_control), .power_down_select(power_down_select),
    .system_source_select(system_source_select), .core_divisor_select(core_divisor_select)
);
`default_nettype wire

// >>> dv/test_subtract_skip_speed_swap_exec.sv
// random and directed bench for the subtract, skip, speed and swap block
`timescale 1ns/1ps
`default_nettype none
module test_subtract_skip_speed_swap_exec;
    logic        core_clk = 0, reset, instr_valid, instr_ready, mem_we, retire;
    logic        skip_next, unknown_op, ec, edc, ez, eskip, eunk, ewe, sb;
    logic [15:0] instr_word, rw;
    logic  [8:0] mem_raddr, mem_waddr, ewa;
    logic  [7:0] mem_rdata, mem_wdata, w_value, status_flags, cpu_speed_control, ew, espd, ewd;
    logic  [7:0] mem [0:511];
    logic  [7:0] ref_mem [0:511];
    logic  [1:0] power_down_select, system_source_select;
    logic  [3:0] core_divisor_select;
    logic  [6:0] ops [0:8] = '{7'h00, 7'h00, 7'h05, 7'h04, 7'h00, 7'h25, 7'h24, 7'h1D, 7'h00};
    logic [15:0] dir [0:17] = '{16'h7A06, 16'h0A99, 16'h0899, 16'h7A29, 16'h7A06, 16'h7A05,
        16'h6003, 16'h4A99, 16'h4899, 16'h3A99, 16'h01F3, 16'h6003, 16'h012F, 16'h7A06,
        16'h0100, 16'hF123, 16'h0000, 16'h7B00};
    int          err_count, comparisons, cycles, k;
    subtract_skip_speed_swap_exec dut (
        .core_clk(core_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .retire(retire), .skip_next(skip_next),
        .unknown_op(unknown_op), .w_value(w_value), .status_flags(status_flags),
        .cpu_speed_control(cpu_speed_control), .power_down_select(power_down_select),
        .system_source_select(system_source_select), .core_divisor_select(core_divisor_select)
    );
    always #25 core_clk = ~core_clk;
    // asynchronous-read data memory; its write lands late, so back-to-back hits need forwarding
    assign mem_rdata = mem[mem_raddr];
    always @(posedge core_clk)
        if (mem_we) mem[mem_waddr] <= mem_wdata;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    function automatic logic [9:0] sub_exp(input logic [7:0] a, b, input logic bin);
        logic [8:0] d;
        logic [4:0] n;
        d = {1'b0, a} - {1'b0, b} - 9'(bin);
        n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bin);
        return {~d[8], ~n[4], d[7:0]};
    endfunction
    task automatic exec(input logic [15:0] wd);
        logic [7:0] rd;
        logic [9:0] s;
        logic [8:0] fld;
        int         dv, low;
        rd = (wd[8:0] == 9'h003) ? {5'h00, ez, edc, ec} : ref_mem[wd[8:0]];
        dv = espd[3:0] + 1;
        {eskip, eunk, ewe, sb, ewa} = {4'h0, wd[8:0]};
        s = sub_exp(wd[15:8] == 8'h7A ? wd[7:0] : rd, ew, wd[14] & ~wd[13] & ~ec);
        casez (wd[15:9])
            7'b0110???: eskip = !rd[wd[11:9]];
            7'h00: {espd, eunk} = wd[8] ? {wd[7:0], 1'b0} : {espd, 1'b1};
            7'h1D: {ewe, ewd} = {1'b1, rd[3:0], rd[7:4]};
            7'h05, 7'h25: {ewe, ewd, sb} = {1'b1, s[7:0], 1'b1};
            7'h04, 7'h24: {ew, sb} = {s[7:0], 1'b1};
            7'h3D: {ew, sb, eunk} = wd[8] ? {ew, 2'b01} : {s[7:0], 2'b10};
            default: eunk = 1;
        endcase
        if (sb) {ec, edc, ez} = {s[9:8], s[7:0] == 8'h00};
        instr_word = wd;
        instr_valid = 1;
        @(negedge core_clk);
        check(9'(retire), 9'h001);
        check(9'(skip_next), 9'(eskip));
        check(9'(unknown_op), 9'(eunk));
        check(mem_raddr, wd[8:0]);
        check(9'(w_value), 9'(ew));
        check(9'(status_flags), {6'h00, ez, edc, ec});
        check(9'(cpu_speed_control), 9'(espd));
        fld = {1'b0, power_down_select, system_source_select, core_divisor_select};
        check(fld, 9'(espd));
        check(9'(mem_we), 9'(ewe));
        if (ewe) check(mem_waddr, ewa);
        if (ewe) check(9'(mem_wdata), 9'(ewd));
        if (ewe) ref_mem[ewa] = ewd;
        // the old word stays offered while busy, so refusal is exercised too
        low = 0;
        while (!instr_ready && low < 40) begin
            low++;
            @(negedge core_clk);
            check(9'({retire, mem_we}), 9'h000);
        end
        if (!eunk) check(9'(low), 9'(dv * (eskip ? 2 : 1) - 1));
    endtask
    initial begin
        void'($urandom(1238));
        {reset, instr_valid, instr_word, ew, espd} = {2'b10, 16'h0000, 8'h00, subskip_pkg::SPEED_RESET};
        {ec, edc, ez} = 3'b000;
        for (int i = 0; i < 512; i++) begin
            mem[i] = (i == 'h099) ? 8'h35 : 8'($urandom);
            ref_mem[i] = mem[i];
        end
        repeat (8) @(negedge core_clk);
        check(9'(instr_ready), 9'h001);
        check(9'(status_flags), 9'h000);
        check(9'(cpu_speed_control), 9'(subskip_pkg::SPEED_RESET));
        reset = 0;
        @(negedge core_clk);
        foreach (dir[i]) exec(dir[i]);
        repeat (300) begin
            k = $urandom % 9;
            case (k)
                0: rw = {4'h6, 3'($urandom), 9'($urandom_range(511, 3))};
                1: rw = {8'h01, 8'($urandom)};
                4: rw = {8'h7A, 8'($urandom)};
                8: rw = {4'hF, 12'($urandom)};
                default: rw = {ops[k], 9'($urandom_range(511, 4))};
            endcase
            exec(rw);
        end
        instr_valid = 0;
        repeat (4) @(negedge core_clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
